// ---- bench/ccoc_emitter.sv ----
// Remote-control emitter model: measures the carrier cycle on the pin
`default_nettype none
module ccoc_emitter (
	input  wire logic        clk_sys,
	input  wire logic        pin,
	output var  logic [15:0] per
);
	timeunit 1ns;
	timeprecision 1ps;
	logic        last = 1'b0;
	logic [15:0] cnt = 16'h0000;
	initial per = 16'h0000;
	always @(posedge clk_sys) begin
		last <= pin;
		cnt <= (pin && !last) ? 16'h0001 : cnt + 16'h0001;
		if (pin && !last)
			per <= cnt;
	end
endmodule // ccoc_emitter
`default_nettype wire

// ---- bench/ccoc_top_asserts.sv ----
// Assertion checker bound to the carrier channel top
`default_nettype none
`include "ccoc_map.vh"
module ccoc_chk #(
	parameter [15:0] CNT_DIV = 16'h0001
) (
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic [5:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        start_trigger_in,
	input wire logic        slave_channel_interrupt,
	input wire logic        carrier_channel_interrupt,
	input wire logic        carrier_out,
	input wire logic        irq
);
	timeunit 1ns;
	timeprecision 1ps;
	wire         wa = avs_write & ~avs_waitrequest;
	logic        en_q, om_q, pol_q, gok_q;
	logic [15:0] per_q;
	logic [31:0] gap_q;
	// Shadow of the period, output mode, polarity and enable registers as written over the bus
	always @(posedge clk_sys) begin
		if (rst) begin
			en_q <= 1'b0;
			om_q <= 1'b0;
			pol_q <= 1'b0;
			gok_q <= 1'b0;
			per_q <= 16'h0000;
		end else begin
			if (wa && avs_address == `CCOC_OFS_PERIOD)
				per_q <= avs_writedata[15:0];
			if (wa && avs_address == `CCOC_OFS_OMODE)
				om_q <= avs_writedata[4];
			if (wa && avs_address == `CCOC_OFS_POL)
				pol_q <= avs_writedata[4];
			if (wa && avs_address == `CCOC_OFS_OE)
				en_q <= avs_writedata[4];
			// Gap valid only between undisturbed interrupts
			gok_q <= (gok_q | carrier_channel_interrupt) & ~wa & ~start_trigger_in;
		end
		gap_q <= carrier_channel_interrupt ? 32'h1 : gap_q + 32'h1;
	end
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	wait_state_a:
		assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("access not answered after one wait state");
	toggle_on_int_a:
		assert property (carrier_channel_interrupt && en_q && !om_q && $stable(pol_q)
			|-> carrier_out != $past(carrier_out)) else $error("pin did not toggle");
	hold_when_off_a:
		assert property (!en_q && !$past(en_q) && !$past(wa) && !$past(wa, 2)
			|-> $stable(carrier_out)) else $error("pin moved while disabled");
	level_ignored_a:
		assert property (en_q && wa && avs_address == `CCOC_OFS_LEVEL && !slave_channel_interrupt
			##1 !carrier_channel_interrupt |-> $stable(carrier_out))
		else $error("level write took effect while enabled");
	slave_set_a:
		assert property (carrier_channel_interrupt && en_q && om_q |-> carrier_out == !pol_q)
		else $error("pin not set by channel interrupt");
	slave_clr_a:
		assert property (en_q && om_q && slave_channel_interrupt ##1 !carrier_channel_interrupt
			|-> carrier_out == pol_q) else $error("pin not cleared by slave interrupt");
	reserved_zero_a:
		assert property (avs_read && !avs_waitrequest && avs_address inside {`CCOC_OFS_OMODE,
			`CCOC_OFS_POL, `CCOC_OFS_LEVEL, `CCOC_OFS_OE} |-> (avs_readdata & 32'hffffffef) == 0)
		else $error("reserved output bits read nonzero");
	period_len_a:
		assert property (carrier_channel_interrupt && gok_q
			|-> gap_q == (per_q + 32'h1) * CNT_DIV) else $error("wrong carrier period");
	cover property (carrier_channel_interrupt && om_q);
	cover property (carrier_channel_interrupt && gok_q);
	cover property (irq);
endmodule // ccoc_chk
bind ccoc_top ccoc_chk #(.CNT_DIV(CNT_DIV)) i_ccoc_chk (.*);
`default_nettype wire

// ---- bench/tb_top.sv ----
// Self-checking bench for the carrier channel
`default_nettype none
`include "ccoc_map.vh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
	$display("BAD %0t %h %h", $time, a, b); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic [5:0]  avs_address = 6'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic        trig = 1'b0;
	logic        slv = 1'b0;
	logic [31:0] rd_d;
	logic        b;
	wire  [31:0] avs_readdata;
	wire         avs_waitrequest, cci, pin, irq;
	wire  [15:0] per;
	int          error_cnt = 0, checks = 0, cyc = 0, icnt = 0, n0;
	always #2 clk_sys = ~clk_sys;
	ccoc_top #(.CNT_DIV(16'h0001)) i_ccoc_top (.clk_sys(clk_sys), .rst(rst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .start_trigger_in(trig),
		.slave_channel_interrupt(slv), .carrier_channel_interrupt(cci), .carrier_out(pin),
		.irq(irq));
	ccoc_emitter i_ccoc_emitter (.clk_sys(clk_sys), .pin(pin), .per(per));
	always @(posedge clk_sys) begin
		cyc++;
		if (cci === 1'b1)
			icnt++;
		if (cyc == 5000) begin
			error_cnt++;
			stop_test();
		end
	end
	task automatic stop_test;
		if (error_cnt == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic w(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic acc(input logic wr, input logic [5:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		// Hold the request until the edge that sees waitrequest low
		do
			@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0);
		rd_d = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic pulse(input logic s);
		@(posedge clk_sys);
		slv <= s;
		trig <= !s;
		@(posedge clk_sys);
		slv <= 1'b0;
		trig <= 1'b0;
	endtask
	task automatic run(input logic [31:0] p, input logic [31:0] md);
		acc(1, `CCOC_OFS_PERIOD, p);
		acc(1, `CCOC_OFS_OE, 32'h10);
		acc(1, `CCOC_OFS_MODE, md);
		b = pin;
		n0 = icnt;
		acc(1, `CCOC_OFS_CTRL, 32'h1);
		w(3);
	endtask
	task automatic t_regs;
		acc(0, 6'h3c, 0);
		`CHK(rd_d, 32'h0)
		acc(1, `CCOC_OFS_POL, 32'hffffffff);
		acc(0, `CCOC_OFS_POL, 0);
		`CHK(rd_d, 32'h10)
		`CHK(pin, 1'b1)
		acc(1, `CCOC_OFS_LEVEL, 32'h10);
		acc(1, `CCOC_OFS_POL, 0);
		acc(0, `CCOC_OFS_LEVEL, 0);
		`CHK(rd_d, 32'h10)
		`CHK(pin, 1'b1)
		acc(1, `CCOC_OFS_LEVEL, 0);
	endtask
	task automatic t_interval;
		run(32'h9, 32'h0);
		`CHK(icnt, n0)
		`CHK(pin, b)
		w(60);
		`CHK(per, 16'h14)
		acc(1, `CCOC_OFS_LEVEL, 32'h10);
		acc(1, `CCOC_OFS_CTRL, 32'h2);
		acc(1, `CCOC_OFS_OE, 0);
		acc(0, `CCOC_OFS_LEVEL, 0);
		w(30);
		`CHK(pin, rd_d[4])
		acc(1, `CCOC_OFS_LEVEL, {27'h0, ~rd_d[4], 4'h0});
		w(1);
		`CHK(pin, ~rd_d[4])
		run(32'h9, 32'h1);
		`CHK(icnt, n0 + 1)
		`CHK(pin, ~b)
		acc(1, `CCOC_OFS_CTRL, 32'h2);
	endtask
	task automatic t_one;
		for (int o = 0; o < 2; o++) begin
			run(32'h14, o ? 32'h9 : 32'h8);
			pulse(0);
			w(5);
			pulse(0);
			w(60);
			`CHK(icnt - n0, 1 + o)
			acc(1, `CCOC_OFS_CTRL, 32'h2);
		end
	endtask
	task automatic t_modes;
		// Capture mode with the option set: interrupt at start
		run(32'h5, 32'h5);
		`CHK(icnt, n0 + 1)
		`CHK(pin, ~b)
		acc(1, `CCOC_OFS_CTRL, 32'h2);
		// Event mode with the option clear: quiet start, interrupt on second event
		run(32'h1, 32'h6);
		`CHK(icnt, n0)
		`CHK(pin, b)
		pulse(0);
		pulse(0);
		w(3);
		`CHK(icnt - n0, 1)
		`CHK(pin, ~b)
		acc(1, `CCOC_OFS_CTRL, 32'h2);
	endtask
	task automatic t_slave_irq;
		acc(1, `CCOC_OFS_MASK, 32'h1);
		acc(1, `CCOC_OFS_OMODE, 32'h10);
		run(32'h3, 32'h0);
		repeat (4) begin
			pulse(1);
			w(2);
		end
		acc(1, `CCOC_OFS_CTRL, 32'h2);
		pulse(1);
		w(2);
		`CHK(pin, 1'b0)
		`CHK(irq, 1'b1)
		acc(0, `CCOC_OFS_STAT, 0);
		`CHK(rd_d[0], 1'b1)
		pulse(1);
		w(1);
		`CHK(irq, 1'b0)
		acc(0, `CCOC_OFS_STAT, 0);
		`CHK(rd_d, 32'h2)
		acc(1, `CCOC_OFS_OMODE, 0);
	endtask
	initial begin
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		t_regs();
		t_interval();
		t_one();
		t_modes();
		t_slave_irq();
		stop_test();
	end
endmodule // tb_top
`default_nettype wire

// ---- logic/ccoc_map.vh ----
// Register map, field positions and mode codes of the carrier channel
`ifndef CCOC_MAP_VH
`define CCOC_MAP_VH

// Byte offsets on the register bus
`define CCOC_OFS_PERIOD   6'h00
`define CCOC_OFS_MODE     6'h04
`define CCOC_OFS_OMODE    6'h08
`define CCOC_OFS_POL      6'h0c
`define CCOC_OFS_LEVEL    6'h10
`define CCOC_OFS_OE       6'h14
`define CCOC_OFS_CTRL     6'h18
`define CCOC_OFS_STAT     6'h1c
`define CCOC_OFS_MASK     6'h20

// Field positions
`define CCOC_CH_BIT       4
`define CCOC_OPT_BIT      0
`define CCOC_MODE_LSB     1
`define CCOC_MODE_MSB     3
`define CCOC_CTRL_START   0
`define CCOC_CTRL_STOP    1
`define CCOC_STAT_CARR    0
`define CCOC_STAT_SLAVE   1

// Mode field codes
`define CCOC_MD_INTERVAL  3'h0
`define CCOC_MD_CAPTURE   3'h2
`define CCOC_MD_EVENT     3'h3
`define CCOC_MD_ONECOUNT  3'h4
`define CCOC_MD_CAPONE    3'h6

// Reset values
`define CCOC_RST_PERIOD   16'h0000
`define CCOC_RST_MODE     4'h0
`define CCOC_RST_BIT      1'b0

// Default count clock divider (system cycles per count tick)
`define CCOC_CNT_DIV      16'h0001

`endif

// ---- logic/ccoc_top.v ----
// Carrier master channel: counter, output control and Avalon-MM registers
`default_nettype none
`include "ccoc_map.vh"

module ccoc_top #(
	parameter [15:0] CNT_DIV = `CCOC_CNT_DIV
) (
	input  wire        clk_sys,
	input  wire        rst,
	input  wire [5:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	input  wire [3:0]  avs_byteenable,
	output wire [31:0] avs_readdata,
	output wire        avs_waitrequest,
	input  wire        start_trigger_in,
	input  wire        slave_channel_interrupt,
	output wire        carrier_channel_interrupt,
	output wire        carrier_out,
	output wire        irq
);

	// Bus handshake: one wait cycle per access
	reg         ack_q;
	reg  [31:0] rdata_q;
	wire        req = avs_read | avs_write;
	wire        wr_go = avs_write & ack_q;
	wire        rd_go = avs_read & ack_q;

	assign avs_waitrequest = req & ~ack_q;
	assign avs_readdata    = rdata_q;

	// Registers
	reg  [15:0] period_q;
	reg  [3:0]  mode_q;
	reg         omode_q;
	reg         pol_q;
	reg         level_q;
	reg         oe_q;
	reg  [1:0]  stat_q;
	reg  [1:0]  mask_q;
	reg         pin_q;
	reg         int_q;

	// Counter state
	reg  [15:0] cnt_q;
	reg  [15:0] cnt_d;
	reg         run_q;
	reg         run_d;
	reg         arm_q;
	reg         arm_d;
	reg         fire;
	reg         cap_wr;
	reg  [15:0] div_q;
	reg         level_d;
	reg  [31:0] rdata_d;

	wire [2:0]  md  = mode_q[`CCOC_MODE_MSB:`CCOC_MODE_LSB];
	wire        opt = mode_q[`CCOC_OPT_BIT];
	wire        tick = (div_q == CNT_DIV - 16'h0001);
	wire        sel_period = (avs_address == `CCOC_OFS_PERIOD);
	wire        sel_mode   = (avs_address == `CCOC_OFS_MODE);
	wire        sel_omode  = (avs_address == `CCOC_OFS_OMODE);
	wire        sel_pol    = (avs_address == `CCOC_OFS_POL);
	wire        sel_level  = (avs_address == `CCOC_OFS_LEVEL);
	wire        sel_oe     = (avs_address == `CCOC_OFS_OE);
	wire        sel_ctrl   = (avs_address == `CCOC_OFS_CTRL);
	wire        sel_stat   = (avs_address == `CCOC_OFS_STAT);
	wire        sel_mask   = (avs_address == `CCOC_OFS_MASK);
	wire        lane0 = avs_byteenable[0];
	wire        lane1 = avs_byteenable[1];
	wire        sw_start = wr_go & sel_ctrl & lane0 & avs_writedata[`CCOC_CTRL_START];
	wire        sw_stop  = wr_go & sel_ctrl & lane0 & avs_writedata[`CCOC_CTRL_STOP];

	// Count clock enable from the divider
	always @(posedge clk_sys) begin
		if (rst || tick) begin
			div_q <= 16'h0000;
		end else begin
			div_q <= div_q + 16'h0001;
		end
	end

	// Counter next state and interrupt generation
	always @* begin
		cnt_d  = cnt_q;
		run_d  = run_q;
		arm_d  = arm_q;
		fire   = 1'b0;
		cap_wr = 1'b0;
		if (sw_stop) begin
			run_d = 1'b0;
			arm_d = 1'b0;
		end else if (sw_start) begin
			case (md)
				`CCOC_MD_INTERVAL: begin
					cnt_d = period_q;
					run_d = 1'b1;
					fire  = opt;
				end
				`CCOC_MD_CAPTURE: begin
					cnt_d = 16'h0000;
					run_d = 1'b1;
					fire  = opt;
				end
				`CCOC_MD_EVENT: begin
					cnt_d = period_q;
					run_d = 1'b1;
				end
				`CCOC_MD_ONECOUNT, `CCOC_MD_CAPONE: begin
					arm_d = 1'b1;
				end
				default: begin
					run_d = 1'b0;
				end
			endcase
		end else if (run_q || arm_q) begin
			case (md)
				`CCOC_MD_INTERVAL: begin
					if (tick) begin
						if (cnt_q == 16'h0000) begin
							fire  = 1'b1;
							cnt_d = period_q;
						end else begin
							cnt_d = cnt_q - 16'h0001;
						end
					end
				end
				`CCOC_MD_CAPTURE: begin
					if (start_trigger_in) begin
						cap_wr = 1'b1;
						fire   = 1'b1;
						cnt_d  = 16'h0000;
					end else if (tick) begin
						cnt_d = cnt_q + 16'h0001;
					end
				end
				`CCOC_MD_EVENT: begin
					if (start_trigger_in) begin
						if (cnt_q == 16'h0000) begin
							fire  = 1'b1;
							cnt_d = period_q;
						end else begin
							cnt_d = cnt_q - 16'h0001;
						end
					end
				end
				`CCOC_MD_ONECOUNT: begin
					if (start_trigger_in && (!run_q || opt)) begin
						cnt_d = period_q;
						run_d = 1'b1;
						fire  = run_q;
					end else if (run_q && tick) begin
						if (cnt_q == 16'h0000) begin
							fire  = 1'b1;
							run_d = 1'b0;
						end else begin
							cnt_d = cnt_q - 16'h0001;
						end
					end
				end
				`CCOC_MD_CAPONE: begin
					if (start_trigger_in && !run_q) begin
						cnt_d = 16'h0000;
						run_d = 1'b1;
					end else if (run_q && start_trigger_in) begin
						cap_wr = 1'b1;
						fire   = 1'b1;
						run_d  = 1'b0;
					end else if (run_q && tick) begin
						cnt_d = cnt_q + 16'h0001;
					end
				end
				default: begin
					run_d = 1'b0;
					arm_d = 1'b0;
				end
			endcase
		end
	end

	// Output level latch
	always @* begin
		level_d = level_q;
		if (oe_q) begin
			if (!omode_q) begin
				if (fire) begin
					level_d = ~level_q;
				end
			end else if (fire) begin
				level_d = 1'b1;
			end else if (slave_channel_interrupt) begin
				level_d = 1'b0;
			end
		end else if (wr_go && sel_level && lane0) begin
			level_d = avs_writedata[`CCOC_CH_BIT];
		end
	end

	// Read mux, reserved bits zero
	always @* begin
		rdata_d = 32'h0000_0000;
		if (sel_period) begin
			rdata_d[15:0] = period_q;
		end
		if (sel_mode) begin
			rdata_d[3:0] = mode_q;
		end
		if (sel_omode) begin
			rdata_d[`CCOC_CH_BIT] = omode_q;
		end
		if (sel_pol) begin
			rdata_d[`CCOC_CH_BIT] = pol_q;
		end
		if (sel_level) begin
			rdata_d[`CCOC_CH_BIT] = level_q;
		end
		if (sel_oe) begin
			rdata_d[`CCOC_CH_BIT] = oe_q;
		end
		if (sel_ctrl) begin
			rdata_d[`CCOC_CTRL_START] = run_q | arm_q;
		end
		if (sel_stat) begin
			rdata_d[1:0] = stat_q;
		end
		if (sel_mask) begin
			rdata_d[1:0] = mask_q;
		end
	end

	always @(posedge clk_sys) begin
		if (rst) begin
			ack_q    <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			period_q <= `CCOC_RST_PERIOD;
			mode_q   <= `CCOC_RST_MODE;
			omode_q  <= `CCOC_RST_BIT;
			pol_q    <= `CCOC_RST_BIT;
			level_q  <= `CCOC_RST_BIT;
			oe_q     <= `CCOC_RST_BIT;
			stat_q   <= 2'h0;
			mask_q   <= 2'h0;
			cnt_q    <= 16'h0000;
			run_q    <= 1'b0;
			arm_q    <= 1'b0;
			int_q    <= 1'b0;
			pin_q    <= 1'b0;
		end else begin
			ack_q   <= req & ~ack_q;
			if (req && !ack_q) begin
				rdata_q <= rdata_d;
			end
			cnt_q   <= cnt_d;
			run_q   <= run_d;
			arm_q   <= arm_d;
			int_q   <= fire;
			level_q <= level_d;
			pin_q   <= level_d ^ pol_q;
			// Capture overrides a software write to the compare value
			if (cap_wr) begin
				period_q <= cnt_q;
			end else if (wr_go && sel_period) begin
				if (lane0) begin
					period_q[7:0] <= avs_writedata[7:0];
				end
				if (lane1) begin
					period_q[15:8] <= avs_writedata[15:8];
				end
			end
			if (wr_go && lane0) begin
				if (sel_mode) begin
					mode_q <= avs_writedata[3:0];
				end
				if (sel_omode) begin
					omode_q <= avs_writedata[`CCOC_CH_BIT];
				end
				if (sel_pol) begin
					pol_q <= avs_writedata[`CCOC_CH_BIT];
				end
				if (sel_oe) begin
					oe_q <= avs_writedata[`CCOC_CH_BIT];
				end
				if (sel_mask) begin
					mask_q <= avs_writedata[1:0];
				end
			end
			// Read clears, a new event in the same cycle wins
			stat_q[`CCOC_STAT_CARR]  <= fire |
				(stat_q[`CCOC_STAT_CARR] & ~(rd_go & sel_stat));
			stat_q[`CCOC_STAT_SLAVE] <= slave_channel_interrupt |
				(stat_q[`CCOC_STAT_SLAVE] & ~(rd_go & sel_stat));
		end
	end

	assign carrier_channel_interrupt = int_q;
	assign carrier_out               = pin_q;
	assign irq                       = |(stat_q & mask_q);

endmodule // ccoc_top
`default_nettype wire
